// File: hdl/multibit_ecc_engine.sv
// Multibit BCH ECC engine with Avalon-MM register slave and NAND byte stream input.
`timescale 1ns/100ps
`default_nettype none
`include "ecc_engine_map.svh"
module multibit_ecc_engine #(
   parameter logic [335:0] GEN_POLY = {42{8'hB5}}
) (
   // Clock and reset.
   input  wire logic        clk,
   input  wire logic        arst_n,
   // Avalon-MM slave.
   input  wire logic [11:0] address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   output logic      [31:0] readdata,
   output logic             waitrequest,
   // NAND data stream seen by the static memory controller.
   input  wire logic [7:0]  nand_data,
   input  wire logic        nand_data_valid,
   // Error interrupt.
   output logic             irq
);
   import ecc_engine_pkg::*;

   eng_state_t   state_reg;
   logic [2:0]   cap_reg;
   logic         sec1k_reg, write_sel_reg, spare_prot_reg, auto_reg;
   logic [1:0]   nsec_reg;
   logic [8:0]   spare_size_reg, ecc_start_reg, ecc_end_reg;
   logic [7:0]   err_stat_reg;
   logic [31:0]  rdata_reg;
   logic         wait_reg, irq_reg;
   logic [10:0]  byte_cnt_reg;
   logic [2:0]   sector_reg, esec_reg;
   logic [8:0]   spare_cnt_reg;
   logic [5:0]   ebyte_reg;
   logic [335:0] lfsr_reg;
   logic         user_reg;
   logic [7:0]   rmem [0:7][0:`MAX_ECC_BYTES-1];

   // Table lookups; capability codes map to 2/4/8/12/24 bits.
   logic [29:0]  tbl;
   logic [5:0]   nb;
   logic [10:0]  sec_last;
   logic [2:0]   sec_max;
   logic [335:0] pmask;
   always_comb begin
      tbl = sec1k_reg ? `ECC_BYTES_1K : `ECC_BYTES_512;
      nb = (cap_reg > 3'h4) ? tbl[5:0] : tbl[6*cap_reg +: 6];
      sec_last = sec1k_reg ? `SEC_LEN_1K : `SEC_LEN_512;
      sec_max = 3'((4'h1 << nsec_reg) - 4'h1);
      pmask = ~(336'h0) >> (9'd336 - {nb, 3'h0});
   end

   // One byte through the shortened BCH division, MSB first.
   function automatic logic [335:0] bch_step(input logic [335:0] r, input logic [7:0] d,
                                             input logic [8:0] len, input logic [335:0] m);
      logic fb;
      for (int i = 7; i >= 0; i--) begin
         fb = r[len - 9'h1] ^ d[i];
         r = (r << 1) & m;
         if (fb) begin
            r = r ^ (GEN_POLY & m);
         end
      end
      return r;
   endfunction

   // Bus handshake; every access takes one wait cycle.
   logic wr_acc, rd_acc;
   assign wr_acc = write & ~wait_reg;
   assign rd_acc = read & ~wait_reg;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wait_reg <= 1'b1;
      end else begin
         wait_reg <= ~((read | write) & wait_reg);
      end
   end

   // Configuration registers.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cap_reg <= 3'h0;
         sec1k_reg <= 1'b0;
         nsec_reg <= 2'h0;
         write_sel_reg <= 1'b0;
         spare_prot_reg <= 1'b0;
         auto_reg <= 1'b0;
         spare_size_reg <= 9'h000;
         ecc_start_reg <= 9'h000;
         ecc_end_reg <= 9'h000;
      end else if (wr_acc && state_reg == ST_IDLE) begin
         // Settings are frozen while a page is in flight to keep counters coherent.
         case (address)
            `OFS_CFG: begin
               cap_reg <= writedata[`CFG_CAP_LSB +: 3];
               sec1k_reg <= writedata[`CFG_SEC1K_BIT];
               nsec_reg <= writedata[`CFG_NSEC_LSB +: 2];
               write_sel_reg <= writedata[`CFG_WRITE_BIT];
               spare_prot_reg <= writedata[`CFG_SPARE_BIT];
               auto_reg <= writedata[`CFG_AUTO_BIT];
            end
            `OFS_SPARE: spare_size_reg <= writedata[8:0];
            `OFS_ECC_START: ecc_start_reg <= writedata[8:0];
            `OFS_ECC_END: ecc_end_reg <= writedata[8:0];
            default: ;
         endcase
      end
   end

   // Start pulses and stream qualifiers.
   logic go_data, go_user, dv, in_ecc, last_sec_byte, last_sec, spare_end;
   assign go_data = wr_acc && address == `OFS_CTRL && writedata[`CTRL_DATA_BIT] && state_reg == ST_IDLE;
   assign go_user = wr_acc && address == `OFS_CTRL && writedata[`CTRL_USER_BIT] && state_reg == ST_IDLE
                    && !writedata[`CTRL_DATA_BIT];
   assign dv = nand_data_valid;
   assign in_ecc = spare_cnt_reg >= ecc_start_reg && spare_cnt_reg <= ecc_end_reg;
   assign last_sec_byte = byte_cnt_reg == sec_last;
   assign last_sec = sector_reg == sec_max;
   assign spare_end = (user_reg ? spare_cnt_reg == ecc_end_reg : spare_cnt_reg + 9'h1 >= spare_size_reg);

   // Sequencer: data sectors, then spare or ECC area, then the check.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= ST_IDLE;
         byte_cnt_reg <= 11'h000;
         sector_reg <= 3'h0;
         spare_cnt_reg <= 9'h000;
         user_reg <= 1'b0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               byte_cnt_reg <= 11'h000;
               sector_reg <= 3'h0;
               if (go_data) begin
                  state_reg <= ST_DATA;
                  user_reg <= 1'b0;
                  spare_cnt_reg <= 9'h000;
               end else if (go_user) begin
                  state_reg <= ST_SPARE;
                  user_reg <= 1'b1;
                  spare_cnt_reg <= ecc_start_reg;
               end
            end
            ST_DATA: if (dv) begin
               byte_cnt_reg <= last_sec_byte ? 11'h000 : byte_cnt_reg + 11'h001;
               if (last_sec_byte) begin
                  if (!last_sec) begin
                     sector_reg <= sector_reg + 3'h1;
                  end else if (spare_prot_reg || (!write_sel_reg && auto_reg)) begin
                     state_reg <= ST_SPARE;
                  end else begin
                     state_reg <= ST_CHECK;
                  end
               end
            end
            ST_SPARE: if (dv) begin
               spare_cnt_reg <= spare_cnt_reg + 9'h1;
               if (spare_end) begin
                  state_reg <= ST_CHECK;
               end
            end
            ST_CHECK: state_reg <= ST_IDLE;
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // Division register: a sector's data, plus protected spare bytes for the last one.
   logic lfsr_feed, lfsr_done;
   logic [335:0] lfsr_next;
   assign lfsr_feed = dv && (state_reg == ST_DATA || (state_reg == ST_SPARE && spare_prot_reg && !user_reg
                      && !in_ecc));
   assign lfsr_done = dv && ((state_reg == ST_DATA && last_sec_byte && !(last_sec && spare_prot_reg))
                      || (state_reg == ST_SPARE && spare_end && spare_prot_reg && !user_reg));
   assign lfsr_next = lfsr_feed ? bch_step(lfsr_reg, nand_data, {nb, 3'h0}, pmask) : lfsr_reg;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         lfsr_reg <= 336'h0;
      end else if (go_data || lfsr_done) begin
         lfsr_reg <= 336'h0;
      end else if (lfsr_feed) begin
         lfsr_reg <= lfsr_next;
      end
   end

   // ECC-area pointer: which sector and byte the next stored ECC byte belongs to.
   logic ecc_take;
   assign ecc_take = dv && state_reg == ST_SPARE && in_ecc && !write_sel_reg && (user_reg || !spare_prot_reg);
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         esec_reg <= 3'h0;
         ebyte_reg <= 6'h00;
      end else if (go_data || go_user) begin
         esec_reg <= 3'h0;
         ebyte_reg <= 6'h00;
      end else if (ecc_take) begin
         ebyte_reg <= (ebyte_reg == nb - 6'h1) ? 6'h00 : ebyte_reg + 6'h01;
         if (ebyte_reg == nb - 6'h1) begin
            esec_reg <= esec_reg + 3'h1;
         end
      end
   end

   // Redundancy and remainder store. Since the data part is divided as d*x^L,
   // the codeword remainder is that result xored with the stored ECC bytes.
   logic [2:0] done_sec;
   assign done_sec = sector_reg;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rmem <= '{default: 8'h00};
      end else if (go_data) begin
         rmem <= '{default: 8'h00};
      end else if (lfsr_done) begin
         for (int b = 0; b < `MAX_ECC_BYTES; b++) begin
            rmem[done_sec][b] <= rmem[done_sec][b] ^ lfsr_next[8*b +: 8];
         end
      end else if (ecc_take && esec_reg <= sec_max) begin
         rmem[esec_reg][ebyte_reg] <= rmem[esec_reg][ebyte_reg] ^ nand_data;
      end
   end

   // Per-sector nonzero detection over the active remainder bytes.
   logic [7:0] nz;
   always_comb begin
      nz = 8'h00;
      for (int s = 0; s < 8; s++) begin
         for (int b = 0; b < `MAX_ECC_BYTES; b++) begin
            if (b < nb && 3'(s) <= sec_max && rmem[s][b] != 8'h00) begin
               nz[s] = 1'b1;
            end
         end
      end
   end

   // Error status: set by the check, cleared by a read; a set in the same cycle wins.
   logic [7:0] set_mask;
   logic       stat_rd, chk_dec;
   // A protected read pass holds no ECC bytes yet, so only the later user pass may judge it.
   assign chk_dec = state_reg == ST_CHECK && !write_sel_reg && (user_reg || (auto_reg && !spare_prot_reg));
   assign set_mask = chk_dec ? nz : 8'h00;
   assign stat_rd = rd_acc && address == `OFS_ERR_STAT;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         err_stat_reg <= 8'h00;
      end else begin
         err_stat_reg <= (stat_rd ? 8'h00 : err_stat_reg) | set_mask;
      end
   end

   // Interrupt follows the flags with one cycle of lag.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= |err_stat_reg;
      end
   end

   // Read data is captured in the wait cycle and stands while waitrequest is low.
   logic [2:0] rd_sec;
   logic [3:0] rd_word;
   assign rd_sec = address[8:6];
   assign rd_word = address[5:2];
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_reg <= 32'h0000_0000;
      end else if (read && wait_reg) begin
         rdata_reg <= 32'h0000_0000;
         if (address >= `OFS_REDUN_BASE && address[11:9] == 3'h1 && address[1:0] == 2'h0) begin
            for (int k = 0; k < 4; k++) begin
               if ({rd_word, 2'(k)} < nb) begin
                  rdata_reg[8*k +: 8] <= rmem[rd_sec][{rd_word, 2'(k)}];
               end
            end
         end else begin
            case (address)
               `OFS_CFG: rdata_reg <= {11'h0, auto_reg, 3'h0, spare_prot_reg, 3'h0, write_sel_reg,
                                       2'h0, nsec_reg, 3'h0, sec1k_reg, 1'b0, cap_reg};
               `OFS_SPARE: rdata_reg <= {23'h0, spare_size_reg};
               `OFS_ECC_START: rdata_reg <= {23'h0, ecc_start_reg};
               `OFS_ECC_END: rdata_reg <= {23'h0, ecc_end_reg};
               `OFS_STATE: rdata_reg <= {27'h0, sector_reg, state_reg};
               `OFS_ERR_STAT: rdata_reg <= {24'h0, err_stat_reg | set_mask};
               default: rdata_reg <= 32'h0000_0000;
            endcase
         end
      end
   end

   assign readdata = rdata_reg;
   assign waitrequest = wait_reg;
   assign irq = irq_reg;

   // Checks.
   property p_wait;
      @(posedge clk) disable iff (!arst_n) (read || write) && waitrequest |=> !waitrequest ##1 waitrequest;
   endproperty
   a_wait: assert property (p_wait) else $error("waitrequest did not drop for one cycle");
   property p_irq;
      @(posedge clk) disable iff (!arst_n) (err_stat_reg != 8'h00) |=> irq;
   endproperty
   a_irq: assert property (p_irq) else $error("irq missing after error flag");
   property p_clear;
      @(posedge clk) disable iff (!arst_n) stat_rd && set_mask == 8'h00 |=> err_stat_reg == 8'h00 ##1 !irq;
   endproperty
   a_clear: assert property (p_clear) else $error("status read did not clear");
   property p_start;
      @(posedge clk) disable iff (!arst_n) go_data |=> state_reg == ST_DATA && lfsr_reg == 336'h0;
   endproperty
   a_start: assert property (p_start) else $error("data start not taken");
   property p_sector;
      @(posedge clk) disable iff (!arst_n) state_reg == ST_DATA |-> sector_reg <= sec_max;
   endproperty
   a_sector: assert property (p_sector) else $error("sector index beyond page");
   property p_bytes;
      @(posedge clk) disable iff (!arst_n) dv && state_reg == ST_DATA && last_sec_byte && !last_sec
                                           |=> byte_cnt_reg == 11'h000 && sector_reg == $past(sector_reg) + 3'h1;
   endproperty
   a_bytes: assert property (p_bytes) else $error("sector boundary missed");
   property p_flag;
      @(posedge clk) disable iff (!arst_n) chk_dec |=> (err_stat_reg & nz) == nz;
   endproperty
   a_flag: assert property (p_flag) else $error("corrupted sector not flagged");
   property p_encode;
      @(posedge clk) disable iff (!arst_n) write_sel_reg |-> set_mask == 8'h00 && !ecc_take;
   endproperty
   a_encode: assert property (p_encode) else $error("encoding touched decode state");
   property p_ebyte;
      @(posedge clk) disable iff (!arst_n) ebyte_reg < nb || state_reg == ST_IDLE;
   endproperty
   a_ebyte: assert property (p_ebyte) else $error("ECC byte pointer past redundancy size");
   c_page: cover property (@(posedge clk) disable iff (!arst_n) state_reg == ST_DATA ##1 state_reg == ST_CHECK);
   c_spare: cover property (@(posedge clk) disable iff (!arst_n) state_reg == ST_SPARE && spare_end && dv);
   c_err: cover property (@(posedge clk) disable iff (!arst_n) set_mask != 8'h00);
endmodule
`default_nettype wire

// File: hdl/ecc_engine_map.svh
// Register offsets, field positions and table constants of the multibit ECC engine.
// Notes on behaviour
// - Engine is a binary shortened BCH encoder/decoder for SLC and MLC pages.
// - Correction capability is 2, 4, 8, 12 or 24 bits; redundancy follows it.
// - Sector size is 512 or 1024 bytes.
// - Page holds 1, 2, 4 or 8 sectors, handled one after another.
// - Pages up to 8 KB with 1024-byte sectors, 4 KB with 512-byte sectors.
// - One byte of the 8-bit NAND stream is consumed per transfer.
// - Programmable spare size bounds the spare region after the data sectors.
// - Spare contents may optionally be covered by the redundancy.
// - Writing a page, each sector's redundancy is held readable after it ends.
// - Reading a page, each sector's remainders are kept in readable registers.
// - All remainders zero means clean; any nonzero remainder means corrupted.
// - Corrupted sector raises the interrupt and sets its bit in error status.
// - All configuration and result registers are reachable over the register bus.
// - Redundancy bytes are 4, 7, 13/14, 20/21, 39/42 for capability 0 to 4.
// - Writing data start begins stream work; user start begins ECC-area work.
// - Auto retrieval with spare protection off takes ECC bytes after the data.
`ifndef ECC_ENGINE_MAP_SVH
`define ECC_ENGINE_MAP_SVH
`define OFS_CFG        12'h000
`define OFS_SPARE      12'h004
`define OFS_ECC_START  12'h008
`define OFS_ECC_END    12'h00C
`define OFS_CTRL       12'h010
`define OFS_STATE      12'h014
`define OFS_ERR_STAT   12'h018
`define OFS_REDUN_BASE 12'h200
`define CFG_CAP_LSB    0
`define CFG_SEC1K_BIT  4
`define CFG_NSEC_LSB   8
`define CFG_WRITE_BIT  12
`define CFG_SPARE_BIT  16
`define CFG_AUTO_BIT   20
`define CTRL_DATA_BIT  1
`define CTRL_USER_BIT  2
`define SEC_LEN_512    11'h1FF
`define SEC_LEN_1K     11'h3FF
`define ECC_BYTES_512  {6'h27, 6'h14, 6'h0D, 6'h07, 6'h04}
`define ECC_BYTES_1K   {6'h2A, 6'h15, 6'h0E, 6'h07, 6'h04}
`define MAX_ECC_BYTES  42
`endif

// File: hdl/ecc_engine_pkg.sv
// Types shared by the multibit ECC engine.
package ecc_engine_pkg;
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_DATA  = 2'b01,
      ST_SPARE = 2'b10,
      ST_CHECK = 2'b11
   } eng_state_t;
endpackage

// File: verif/nand_stream_model.sv
// Behavioural NAND data path that replays a page buffer onto the engine's byte stream.
`timescale 1ns/100ps
`default_nettype none
module nand_stream_model (
   // Clock.
   input  wire logic       clk,
   // Byte stream toward the engine.
   output logic      [7:0] nand_data,
   output logic            nand_data_valid
);
   logic [7:0] page [0:8191];

   // The stream starts idle.
   initial begin
      nand_data = 8'h00;
      nand_data_valid = 1'b0;
   end

   // Sends n bytes from index first, one per valid cycle; a nonzero gap stalls one cycle after every eighth byte.
   // Between bytes the bus shows the inverse of the last byte, so a stale byte never looks fresh.
   task automatic send(input int first, input int n, input int gap);
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         nand_data       <= page[first + i];
         nand_data_valid <= 1'b1;
         if (gap != 0 && i % 8 == 7) begin
            @(posedge clk);
            nand_data       <= ~page[first + i];
            nand_data_valid <= 1'b0;
         end
      end
      @(posedge clk);
      nand_data       <= ~page[first + n - 1];
      nand_data_valid <= 1'b0;
   endtask
endmodule
`default_nettype wire

// File: verif/tb.sv
// Self-checking bench for the multibit ECC engine: registers, encode and decode passes.
`timescale 1ns/100ps
`default_nettype none
`include "ecc_engine_map.svh"
module tb;
   import ecc_engine_pkg::*;
   logic        clk;
   logic        arst_n;
   logic [11:0] address;
   logic        read;
   logic        write;
   logic [31:0] writedata;
   logic [31:0] readdata;
   logic        waitrequest;
   logic [7:0]  nand_data;
   logic        nand_data_valid;
   logic        irq;
   int          num_errors = 0;
   int          cmp_count = 0;
   int          cycles = 0;
   int          nb;
   logic [31:0] rd;
   logic [31:0] first_word;
   logic [7:0]  seen_bits;
   int          nb_512 [0:4] = '{4, 7, 13, 20, 39};
   int          nb_1k [0:4] = '{4, 7, 14, 21, 42};

   multibit_ecc_engine uut (.clk(clk), .arst_n(arst_n), .address(address), .read(read), .write(write),
      .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .nand_data(nand_data),
      .nand_data_valid(nand_data_valid), .irq(irq));
   nand_stream_model nsm (.clk(clk), .nand_data(nand_data), .nand_data_valid(nand_data_valid));

   // 250 MHz clock.
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // The whole run needs about 22000 cycles; a hang is cut short well beyond that.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 80000) begin
         num_errors++;
         complete_run();
      end
   end

   // Prints the counts and the verdict, then ends the run.
   task automatic complete_run();
      $display("Counts: %0d comparisons, %0d mismatches", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Counts a comparison and reports a mismatch at once.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   // One register access; the request stands until the rising edge at which waitrequest is seen low.
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      address   <= a;
      writedata <= d;
      write     <= wr;
      read      <= ~wr;
      do @(posedge clk); while (waitrequest !== 1'b0);
      rd = readdata;
      write <= 1'b0;
      read  <= 1'b0;
   endtask

   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input string what);
      bus(1'b0, a, 32'h0);
      check(rd, exp, what);
   endtask

   function automatic logic [11:0] red_addr(input int s, input int w);
      return 12'(`OFS_REDUN_BASE + s * 64 + w * 4);
   endfunction

   // Polls the state register until the engine is idle again.
   task automatic wait_idle();
      do bus(1'b0, `OFS_STATE, 32'h0); while (rd[1:0] !== ST_IDLE);
   endtask

   // Programs the engine, starts a data pass and streams n bytes of the page buffer.
   task automatic run_page(input logic [31:0] cfg, input int n, input int gap);
      bus(1'b1, `OFS_CFG, cfg);
      bus(1'b1, `OFS_CTRL, 32'h0000_0002);
      nsm.send(0, n, gap);
      wait_idle();
   endtask

   // Main sequence.
   initial begin
      arst_n = 1'b0;
      address = 12'h000;
      read = 1'b0;
      write = 1'b0;
      writedata = 32'h0;
      repeat (10) @(posedge clk);
      check({30'h0, waitrequest, irq}, 32'h0000_0002, "outputs in reset");
      arst_n <= 1'b1;
      // Registers come up cleared, unmapped space reads zero, config and spare read back.
      rdchk(`OFS_CFG, 32'h0, "config reset");
      rdchk(`OFS_ERR_STAT, 32'h0, "status reset");
      bus(1'b1, 12'h100, 32'hFFFF_FFFF);
      rdchk(12'h100, 32'h0, "unmapped read");
      bus(1'b1, `OFS_CFG, 32'h0011_1313);
      rdchk(`OFS_CFG, 32'h0011_1313, "config readback");
      bus(1'b1, `OFS_SPARE, 32'h0000_01FF);
      rdchk(`OFS_SPARE, 32'h0000_01FF, "spare size readback");
      $display("test registers done");
      // Every capability and sector size: bytes past the redundancy length read zero.
      for (int i = 0; i < 8192; i++) nsm.page[i] = 8'(i * 7 + 3);
      for (int s = 0; s < 2; s++) begin
         for (int c = 0; c < 5; c++) begin
            run_page(32'h0000_1000 | 32'(s << 4) | 32'(c), 512 << s, 0);
            nb = (s == 1) ? nb_1k[c] : nb_512[c];
            seen_bits = 8'h00;
            for (int w = 0; w < 11; w++) begin
               bus(1'b0, red_addr(0, w), 32'h0);
               for (int b = 0; b < 4; b++) begin
                  if (w * 4 + b >= nb) check({24'h0, rd[b*8 +: 8]}, 32'h0, "byte past length");
                  else seen_bits = seen_bits | rd[b*8 +: 8];
               end
            end
            check({31'h0, seen_bits != 8'h00}, 32'h1, "redundancy present");
         end
      end
      $display("test redundancy lengths done");
      // An 8 KB page of eight 1024-byte sectors yields redundancy for the last sector.
      run_page(32'h0000_1310, 8192, 0);
      bus(1'b0, red_addr(7, 0), 32'h0);
      check({31'h0, rd != 32'h0}, 32'h1, "last sector redundancy");
      $display("test full page done");
      // Encode two sectors with a stalling stream and copy the redundancy into the spare area.
      run_page(32'h0000_1101, 1024, 1);
      for (int s = 0; s < 2; s++) begin
         for (int w = 0; w < 2; w++) begin
            bus(1'b0, red_addr(s, w), 32'h0);
            for (int b = 0; b < 4; b++) begin
               if (w * 4 + b < 7) nsm.page[1024 + s * 7 + w * 4 + b] = rd[b*8 +: 8];
            end
         end
      end
      bus(1'b1, `OFS_SPARE, 32'h0000_000E);
      bus(1'b1, `OFS_ECC_START, 32'h0);
      bus(1'b1, `OFS_ECC_END, 32'h0000_000D);
      // Decode with one bit flipped in the second sector; only that sector is flagged.
      nsm.page[600] = nsm.page[600] ^ 8'h10;
      run_page(32'h0010_0101, 1038, 1);
      @(negedge clk);
      check({31'h0, irq}, 32'h1, "interrupt on error");
      rdchk(`OFS_ERR_STAT, 32'h0000_0002, "second sector flagged");
      repeat (2) @(negedge clk);
      check({31'h0, irq}, 32'h0, "interrupt cleared by read");
      rdchk(`OFS_ERR_STAT, 32'h0, "status cleared by read");
      rdchk(red_addr(0, 0), 32'h0, "clean sector remainder");
      rdchk(red_addr(0, 1), 32'h0, "clean sector remainder");
      bus(1'b0, red_addr(1, 0), 32'h0);
      first_word = rd;
      bus(1'b0, red_addr(1, 1), 32'h0);
      check({31'h0, (first_word | rd) != 32'h0}, 32'h1, "corrupt remainder");
      $display("test decode with error done");
      // A clean page flags nothing, and a config write during the pass is refused.
      nsm.page[600] = nsm.page[600] ^ 8'h10;
      bus(1'b1, `OFS_CTRL, 32'h0000_0002);
      fork
         nsm.send(0, 1038, 1);
         begin
            bus(1'b0, `OFS_STATE, 32'h0);
            check({30'h0, rd[1:0]}, {30'h0, ST_DATA}, "busy state");
            bus(1'b1, `OFS_CFG, 32'h0000_0004);
         end
      join
      wait_idle();
      rdchk(`OFS_CFG, 32'h0010_0101, "config kept while busy");
      rdchk(`OFS_ERR_STAT, 32'h0, "clean page status");
      check({31'h0, irq}, 32'h0, "no interrupt on clean page");
      $display("test clean decode done");
      // With spare protection a free spare byte changes the redundancy.
      bus(1'b1, `OFS_SPARE, 32'h0000_0008);
      bus(1'b1, `OFS_ECC_START, 32'h0000_0004);
      bus(1'b1, `OFS_ECC_END, 32'h0000_0007);
      run_page(32'h0001_1000, 520, 0);
      bus(1'b0, red_addr(0, 0), 32'h0);
      first_word = rd;
      nsm.page[513] = nsm.page[513] ^ 8'h01;
      run_page(32'h0001_1000, 520, 0);
      bus(1'b0, red_addr(0, 0), 32'h0);
      check({31'h0, rd != first_word}, 32'h1, "spare byte covered");
      // Protected read: the data pass skips the ECC area, and only the user pass brings the stored bytes in.
      for (int b = 0; b < 4; b++) nsm.page[516 + b] = rd[b*8 +: 8];
      for (int e = 0; e < 2; e++) begin
         nsm.page[100] = nsm.page[100] ^ 8'(e);
         run_page(32'h0001_0000, 520, 0);
         rdchk(`OFS_ERR_STAT, 32'h0, "no check before user pass");
         bus(1'b1, `OFS_CTRL, 32'h0000_0004);
         nsm.send(516, 4, 0);
         wait_idle();
         rdchk(`OFS_ERR_STAT, 32'(e), "user pass check");
         if (e == 0) rdchk(red_addr(0, 0), 32'h0, "clean protected remainder");
      end
      $display("test spare protection done");
      complete_run();
   end
endmodule
`default_nettype wire
